// file: ldpi_pkg.sv
package ldpi_pkg;

  // data bus and lane groups
  localparam int DATA_W     = 36;
  localparam int HALF_W     = 18;
  localparam int QUARTER_W  = 9;
  localparam int WORD2_W    = 2 * DATA_W;

  // command and address pins
  localparam int ADDR_W     = 21;
  localparam int BANK_W     = 3;

  // array held by this model: bank plus low address bits
  localparam int IDX_ADDR_W = 4;
  localparam int IDX_W      = BANK_W + IDX_ADDR_W;
  localparam int DEPTH      = 1 << IDX_W;

  // lanes driven per configuration
  localparam logic [DATA_W-1:0] LANES_X9  = 36'h0_0000_01FF;
  localparam logic [DATA_W-1:0] LANES_X18 = 36'h0_0003_FFFF;
  localparam logic [DATA_W-1:0] LANES_X36 = 36'hF_FFFF_FFFF;

  // reset values
  localparam logic [DATA_W-1:0]  DATA_RST = 36'h0_0000_0000;
  localparam logic [ADDR_W-1:0]  MODE_RST = 21'h00_0000;
  localparam logic [BANK_W-1:0]  BANK_RST = 3'h0;
  localparam logic [1:0]         SYNC_RST = 2'h0;
  localparam logic [2:0]         TGL_RST  = 3'h0;

  // width strap encoding
  typedef enum logic [1:0] {
    LDPI_X9  = 2'h0,
    LDPI_X18 = 2'h1,
    LDPI_X36 = 2'h2
  } ldpi_width_t;

  // command code is {write_en_n, refresh_n}
  typedef enum logic [1:0] {
    LDPI_CMD_MODE_LOAD = 2'h0,
    LDPI_CMD_WRITE     = 2'h1,
    LDPI_CMD_REFRESH   = 2'h2,
    LDPI_CMD_READ      = 2'h3
  } ldpi_cmd_t;

endpackage

// file: ldpi_device.sv
`timescale 1ns/1ns
// How it works
// - address pins latched on command clock rise
// - mode load takes settings from address pins
// - bank select steers command to its bank
// - write_en_n, refresh_n, chip_sel_n decode the command
// - chip select high ignores commands, work continues
// - write data captured on both data clock edges
// - x36 splits lanes across two write clocks
// - masked beats sampled both edges, never written
// - data bus up to 36 lanes, subsets narrower
// - read beats launched on both output edges
// - output data clocks free running, edge aligned
// - output clocks paired with lower and upper lanes
// - read_valid high with read beats, clock aligned
module ldpi_device (
  // core clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  // core side results
  output logic [ldpi_pkg::ADDR_W-1:0]        mode_settings,
  output logic                               mode_update,
  output logic                               refresh_req,
  output logic [ldpi_pkg::BANK_W-1:0]        refresh_bank,
  // configuration strap
  input  wire logic [1:0]                    width_sel,
  // command pins
  input  wire logic                          cmd_clk,
  input  wire logic                          cmd_clk_n,
  input  wire logic                          chip_sel_n,
  input  wire logic                          write_en_n,
  input  wire logic                          refresh_n,
  input  wire logic [ldpi_pkg::ADDR_W-1:0]   addr_in,
  input  wire logic [ldpi_pkg::BANK_W-1:0]   bank_select,
  // write data clocks and mask
  input  wire logic                          wr_data_clk_lo,
  input  wire logic                          wr_data_clk_hi,
  input  wire logic                          write_mask,
  // data bus
  input  wire logic [ldpi_pkg::DATA_W-1:0]   data_bus_in,
  output logic [ldpi_pkg::DATA_W-1:0]        data_bus_out,
  output logic [ldpi_pkg::DATA_W-1:0]        data_bus_oe,
  // read clocks and valid
  output logic                               rd_data_clk_lo,
  output logic                               rd_data_clk_lo_n,
  output logic                               rd_data_clk_hi,
  output logic                               rd_data_clk_hi_n,
  output logic                               read_valid
);

  localparam int DW = ldpi_pkg::DATA_W;
  localparam int HW = ldpi_pkg::HALF_W;
  logic [1:0]                   lrst_pipe_reg, wsel_meta_reg, wsel_reg;
  ldpi_pkg::ldpi_width_t        width;
  ldpi_pkg::ldpi_cmd_t          cmd_reg;
  logic                         lrst_n, cmd_act_reg, wr_pend_reg;
  logic                         is_rd, is_wr, is_mode, is_ref;
  logic                         lo_mrise_reg, lo_mfall_reg, mask0;
  logic                         hi_mrise_reg, hi_mfall_reg, mask1;
  logic                         rd_pend_reg, valid_rise_reg;
  logic                         valid_fall_reg, mode_tgl_reg, ref_tgl_reg;
  logic [ldpi_pkg::ADDR_W-1:0]  addr_reg, mode_word_reg;
  logic [ldpi_pkg::BANK_W-1:0]  bank_reg, ref_bank_reg;
  logic [ldpi_pkg::IDX_W-1:0]   cmd_idx, wr_idx_reg;
  logic [DW-1:0]                lo_rise_reg, lo_fall_reg, beat0, beat1;
  logic [DW-1:0]                rise_q_reg, beat1_hold_reg, fall_q_reg;
  logic [DW-1:0]                lanes_reg;
  logic [HW-1:0]                hi_rise_reg, hi_fall_reg;
  logic [ldpi_pkg::WORD2_W-1:0] rd_word_reg;
  logic [ldpi_pkg::WORD2_W-1:0] mem [ldpi_pkg::DEPTH];
  logic [2:0]                   mode_sync_reg, ref_sync_reg;
  // link reset: asserts at once, releases on the command clock
  always_ff @(posedge cmd_clk or negedge rst_n) begin
    if (!rst_n) begin
      lrst_pipe_reg <= ldpi_pkg::SYNC_RST;
    end else begin
      lrst_pipe_reg <= {lrst_pipe_reg[0], 1'h1};
    end
  end
  assign lrst_n = lrst_pipe_reg[1];

  // width strap is a pin, so it is synchronised before use
  always_ff @(posedge cmd_clk or negedge rst_n) begin
    if (!rst_n) begin
      wsel_meta_reg <= ldpi_pkg::SYNC_RST;
      wsel_reg      <= ldpi_pkg::SYNC_RST;
    end else begin
      wsel_meta_reg <= width_sel;
      wsel_reg      <= wsel_meta_reg;
    end
  end

  always_comb begin
    if (wsel_reg == ldpi_pkg::LDPI_X9) begin
      width = ldpi_pkg::LDPI_X9;
    end else if (wsel_reg == ldpi_pkg::LDPI_X18) begin
      width = ldpi_pkg::LDPI_X18;
    end else begin
      width = ldpi_pkg::LDPI_X36;
    end
  end

  // command, address and bank pins are synchronous to cmd_clk
  always_ff @(posedge cmd_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      cmd_act_reg <= 1'h0;
      cmd_reg     <= ldpi_pkg::LDPI_CMD_READ;
      addr_reg    <= ldpi_pkg::MODE_RST;
      bank_reg    <= ldpi_pkg::BANK_RST;
    end else begin
      cmd_act_reg <= !chip_sel_n;
      cmd_reg     <= ldpi_pkg::ldpi_cmd_t'({write_en_n, refresh_n});
      addr_reg    <= addr_in;
      bank_reg    <= bank_select;
    end
  end

  assign is_rd   = cmd_act_reg && (cmd_reg == ldpi_pkg::LDPI_CMD_READ);
  assign is_wr   = cmd_act_reg && (cmd_reg == ldpi_pkg::LDPI_CMD_WRITE);
  assign is_mode = cmd_act_reg && (cmd_reg == ldpi_pkg::LDPI_CMD_MODE_LOAD);
  assign is_ref  = cmd_act_reg && (cmd_reg == ldpi_pkg::LDPI_CMD_REFRESH);
  assign cmd_idx = {bank_reg, addr_reg[ldpi_pkg::IDX_ADDR_W-1:0]};

  // write pipeline: beats arrive one command cycle after the command
  always_ff @(posedge cmd_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      wr_pend_reg <= 1'h0;
      wr_idx_reg  <= '0;
    end else begin
      wr_pend_reg <= is_wr;
      if (is_wr) begin
        wr_idx_reg <= cmd_idx;
      end
    end
  end

  // write clocks assumed running and locked to cmd_clk
  always_ff @(posedge wr_data_clk_lo or negedge rst_n) begin
    if (!rst_n) begin
      lo_rise_reg  <= ldpi_pkg::DATA_RST;
      lo_mrise_reg <= 1'h0;
    end else begin
      lo_rise_reg  <= data_bus_in;
      lo_mrise_reg <= write_mask;
    end
  end
  always_ff @(negedge wr_data_clk_lo or negedge rst_n) begin
    if (!rst_n) begin
      lo_fall_reg  <= ldpi_pkg::DATA_RST;
      lo_mfall_reg <= 1'h0;
    end else begin
      lo_fall_reg  <= data_bus_in;
      lo_mfall_reg <= write_mask;
    end
  end
  always_ff @(posedge wr_data_clk_hi or negedge rst_n) begin
    if (!rst_n) begin
      hi_rise_reg  <= '0;
      hi_mrise_reg <= 1'h0;
    end else begin
      hi_rise_reg  <= data_bus_in[DW-1:HW];
      hi_mrise_reg <= write_mask;
    end
  end
  always_ff @(negedge wr_data_clk_hi or negedge rst_n) begin
    if (!rst_n) begin
      hi_fall_reg  <= '0;
      hi_mfall_reg <= 1'h0;
    end else begin
      hi_fall_reg  <= data_bus_in[DW-1:HW];
      hi_mfall_reg <= write_mask;
    end
  end

  // x36 takes upper lanes and mask from the second write clock
  always_comb begin
    if (width == ldpi_pkg::LDPI_X36) begin
      beat0 = {hi_rise_reg, lo_rise_reg[HW-1:0]};
      beat1 = {hi_fall_reg, lo_fall_reg[HW-1:0]};
      mask0 = hi_mrise_reg;
      mask1 = hi_mfall_reg;
    end else begin
      beat0 = lo_rise_reg;
      beat1 = lo_fall_reg;
      mask0 = lo_mrise_reg;
      mask1 = lo_mfall_reg;
    end
  end

  // no reset on the array; contents are undefined until written
  always_ff @(posedge cmd_clk) begin
    if (wr_pend_reg && !mask0) begin
      mem[wr_idx_reg][DW-1:0] <= beat0;
    end
    if (wr_pend_reg && !mask1) begin
      mem[wr_idx_reg][ldpi_pkg::WORD2_W-1:DW] <= beat1;
    end
  end

  // read fetch; a read in the commit cycle sees the older word
  always_ff @(posedge cmd_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      rd_pend_reg <= 1'h0;
      rd_word_reg <= '0;
    end else begin
      rd_pend_reg <= is_rd;
      if (is_rd) begin
        rd_word_reg <= mem[cmd_idx];
      end
    end
  end

  // launch stage: rise beat plus held fall beat, both zero when idle
  always_ff @(posedge cmd_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      valid_rise_reg <= 1'h0;
      rise_q_reg     <= ldpi_pkg::DATA_RST;
      beat1_hold_reg <= ldpi_pkg::DATA_RST;
    end else begin
      valid_rise_reg <= rd_pend_reg;
      if (rd_pend_reg) begin
        rise_q_reg     <= rd_word_reg[DW-1:0];
        beat1_hold_reg <= rd_word_reg[ldpi_pkg::WORD2_W-1:DW];
      end else begin
        rise_q_reg     <= ldpi_pkg::DATA_RST;
        beat1_hold_reg <= ldpi_pkg::DATA_RST;
      end
    end
  end

  always_ff @(negedge cmd_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      valid_fall_reg <= 1'h0;
      fall_q_reg     <= ldpi_pkg::DATA_RST;
    end else begin
      valid_fall_reg <= valid_rise_reg;
      fall_q_reg     <= beat1_hold_reg;
    end
  end

  always_ff @(posedge cmd_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      lanes_reg <= ldpi_pkg::LANES_X36;
    end else if (width == ldpi_pkg::LDPI_X9) begin
      lanes_reg <= ldpi_pkg::LANES_X9;
    end else if (width == ldpi_pkg::LDPI_X18) begin
      lanes_reg <= ldpi_pkg::LANES_X18;
    end else begin
      lanes_reg <= ldpi_pkg::LANES_X36;
    end
  end

  // output clocks follow the command clock, so data edges line up;
  // both pairs always toggle, lane grouping only matters to capture
  assign rd_data_clk_lo   = cmd_clk;
  assign rd_data_clk_lo_n = cmd_clk_n;
  assign rd_data_clk_hi   = cmd_clk;
  assign rd_data_clk_hi_n = cmd_clk_n;
  // edge-aligned double rate: clock level picks rise or fall flop
  assign data_bus_out = cmd_clk ? rise_q_reg : fall_q_reg;
  assign read_valid   = cmd_clk ? valid_rise_reg : valid_fall_reg;
  assign data_bus_oe  = {DW{read_valid}} & lanes_reg;
  // mode word and refresh bank are held still until the next event
  always_ff @(posedge cmd_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      mode_word_reg <= ldpi_pkg::MODE_RST;
      mode_tgl_reg  <= 1'h0;
      ref_bank_reg  <= ldpi_pkg::BANK_RST;
      ref_tgl_reg   <= 1'h0;
    end else begin
      if (is_mode) begin
        mode_word_reg <= addr_reg;
        mode_tgl_reg  <= !mode_tgl_reg;
      end
      if (is_ref) begin
        ref_bank_reg <= bank_reg;
        ref_tgl_reg  <= !ref_tgl_reg;
      end
    end
  end

  // core side: toggles pass two flops, the third finds the edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_sync_reg <= ldpi_pkg::TGL_RST;
      ref_sync_reg  <= ldpi_pkg::TGL_RST;
    end else begin
      mode_sync_reg <= {mode_sync_reg[1:0], mode_tgl_reg};
      ref_sync_reg  <= {ref_sync_reg[1:0], ref_tgl_reg};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_settings <= ldpi_pkg::MODE_RST;
      mode_update   <= 1'h0;
    end else begin
      mode_update <= mode_sync_reg[2] ^ mode_sync_reg[1];
      if (mode_sync_reg[2] ^ mode_sync_reg[1]) begin
        mode_settings <= mode_word_reg;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_req  <= 1'h0;
      refresh_bank <= ldpi_pkg::BANK_RST;
    end else begin
      refresh_req <= ref_sync_reg[2] ^ ref_sync_reg[1];
      if (ref_sync_reg[2] ^ ref_sync_reg[1]) begin
        refresh_bank <= ref_bank_reg;
      end
    end
  end

  sequence s_read_cmd;
    cmd_act_reg && (cmd_reg == ldpi_pkg::LDPI_CMD_READ);
  endsequence
  sequence s_read_beats;
    rd_pend_reg ##1 (valid_rise_reg && read_valid);
  endsequence
  sequence s_write_cmd;
    cmd_act_reg && (cmd_reg == ldpi_pkg::LDPI_CMD_WRITE);
  endsequence

  chk_read_latency: assert property (
    @(posedge cmd_clk) disable iff (!lrst_n)
    s_read_cmd |=> s_read_beats
  ) else $error("read beat not launched two cycles after read");
  chk_read_data: assert property (
    @(posedge cmd_clk) disable iff (!lrst_n)
    rd_pend_reg |=> (rise_q_reg == $past(rd_word_reg[DW-1:0]))
  ) else $error("launched rise beat differs from fetched word");
  chk_valid_quiet: assert property (
    @(posedge cmd_clk) disable iff (!lrst_n)
    !rd_pend_reg |=> (!valid_rise_reg && (rise_q_reg == '0))
  ) else $error("read_valid or data active with no read");
  chk_cs_ignore: assert property (
    @(posedge cmd_clk) disable iff (!lrst_n)
    chip_sel_n |=> ##1 (!wr_pend_reg && !rd_pend_reg)
  ) else $error("command accepted while chip select high");
  chk_write_decode: assert property (
    @(posedge cmd_clk) disable iff (!lrst_n)
    s_write_cmd |=> (wr_pend_reg && (wr_idx_reg == $past(cmd_idx)))
  ) else $error("write not decoded into its bank index");
  chk_mode_capture: assert property (
    @(posedge cmd_clk) disable iff (!lrst_n)
    is_mode |=> ((mode_word_reg == $past(addr_reg))
                 && (mode_tgl_reg != $past(mode_tgl_reg)))
  ) else $error("mode load did not take the address word");
  chk_mask_keep: assert property (
    @(posedge cmd_clk) disable iff (!lrst_n)
    (wr_pend_reg && mask0) |=>
      (mem[$past(wr_idx_reg)][DW-1:0] == $past(mem[wr_idx_reg][DW-1:0]))
  ) else $error("masked beat was written");
  chk_lane_split: assert property (
    @(posedge cmd_clk) disable iff (!lrst_n)
    (wr_pend_reg && !mask0 && (width == ldpi_pkg::LDPI_X36)) |=>
      (mem[$past(wr_idx_reg)][DW-1:HW] == $past(hi_rise_reg))
  ) else $error("upper lanes not taken from second write clock");
  chk_lane_oe: assert property (
    @(posedge cmd_clk) disable iff (!lrst_n)
    (valid_rise_reg && (width == ldpi_pkg::LDPI_X9)
      && $stable(width)) |-> (data_bus_oe == ldpi_pkg::LANES_X9)
  ) else $error("x9 drives lanes outside its group");
endmodule

// file: ldpi_ctrl_model.sv
`timescale 1ns/1ns
module ldpi_ctrl_model (
  // command pins
  output logic                             cmd_clk,
  output logic                             cmd_clk_n,
  output logic                             chip_sel_n,
  output logic                             write_en_n,
  output logic                             refresh_n,
  output logic [ldpi_pkg::ADDR_W-1:0]      addr_in,
  output logic [ldpi_pkg::BANK_W-1:0]      bank_select,
  // write data side
  output logic                             wr_data_clk_lo,
  output logic                             wr_data_clk_hi,
  output logic                             write_mask,
  output logic [ldpi_pkg::DATA_W-1:0]      data_bus_in,
  // device drive
  input  wire logic [ldpi_pkg::DATA_W-1:0] data_bus_out,
  input  wire logic [ldpi_pkg::DATA_W-1:0] data_bus_oe
);
  logic [ldpi_pkg::DATA_W-1:0] drv;

  // lanes the device drives win, the rest carry our own drive
  assign data_bus_in = (data_bus_oe & data_bus_out) | (~data_bus_oe & drv);

  // odd start offset keeps this clock unrelated to mclk
  initial begin
    cmd_clk = 1'b0;
    #5;
    forever #24 cmd_clk = ~cmd_clk;
  end
  assign cmd_clk_n = ~cmd_clk;
  assign wr_data_clk_lo = cmd_clk;
  assign wr_data_clk_hi = cmd_clk;

  initial begin
    chip_sel_n = 1'b1;
    write_en_n = 1'b1;
    refresh_n = 1'b1;
    addr_in = 21'h00_0000;
    bank_select = 3'h0;
    write_mask = 1'b0;
    drv = 36'h0_0000_0000;
  end

  // pins change at the fall, so they are settled at the sampling rise
  task automatic cmd(input logic cs_n, input logic [1:0] code,
                     input logic [ldpi_pkg::ADDR_W-1:0] a,
                     input logic [ldpi_pkg::BANK_W-1:0] b);
    @(negedge cmd_clk);
    chip_sel_n <= cs_n;
    {write_en_n, refresh_n} <= code;
    addr_in <= a;
    bank_select <= b;
  endtask

  // unselected pins do not keep the old value
  task automatic idle();
    @(negedge cmd_clk);
    chip_sel_n <= 1'b1;
    addr_in <= ~addr_in;
    bank_select <= ~bank_select;
  endtask

  task automatic wr(input logic [ldpi_pkg::ADDR_W-1:0] a,
                    input logic [ldpi_pkg::BANK_W-1:0] b,
                    input logic [ldpi_pkg::DATA_W-1:0] d0, d1,
                    input logic m0, m1);
    cmd(1'b0, ldpi_pkg::LDPI_CMD_WRITE, a, b);
    idle();
    drv <= d0;
    write_mask <= m0;
    @(posedge cmd_clk);
    drv <= d1;
    write_mask <= m1;
    @(negedge cmd_clk);
    drv <= ~d1;
    write_mask <= ~m1;
  endtask
endmodule

// file: testbench.sv
`timescale 1ns/1ns
module testbench;
  logic                        mclk;
  logic                        rst_n;
  logic [1:0]                  width_sel;
  logic [20:0]                 mode_settings;
  logic                        mode_update, refresh_req, read_valid;
  logic [2:0]                  refresh_bank, bank_select;
  logic                        cmd_clk, cmd_clk_n, chip_sel_n;
  logic                        write_en_n, refresh_n, write_mask;
  logic [20:0]                 addr_in;
  logic                        wr_data_clk_lo, wr_data_clk_hi;
  logic [35:0]                 data_bus_in, data_bus_out, data_bus_oe;
  logic                        rd_data_clk_lo, rd_data_clk_lo_n;
  logic                        rd_data_clk_hi, rd_data_clk_hi_n;
  int                          err_total, checked;

  ldpi_device u_dut (.mclk(mclk), .rst_n(rst_n),
    .mode_settings(mode_settings), .mode_update(mode_update),
    .refresh_req(refresh_req), .refresh_bank(refresh_bank),
    .width_sel(width_sel), .cmd_clk(cmd_clk), .cmd_clk_n(cmd_clk_n),
    .chip_sel_n(chip_sel_n), .write_en_n(write_en_n),
    .refresh_n(refresh_n), .addr_in(addr_in), .bank_select(bank_select),
    .wr_data_clk_lo(wr_data_clk_lo), .wr_data_clk_hi(wr_data_clk_hi),
    .write_mask(write_mask), .data_bus_in(data_bus_in),
    .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
    .rd_data_clk_lo(rd_data_clk_lo), .rd_data_clk_lo_n(rd_data_clk_lo_n),
    .rd_data_clk_hi(rd_data_clk_hi), .rd_data_clk_hi_n(rd_data_clk_hi_n),
    .read_valid(read_valid));

  ldpi_ctrl_model u_ctrl (.cmd_clk(cmd_clk), .cmd_clk_n(cmd_clk_n),
    .chip_sel_n(chip_sel_n), .write_en_n(write_en_n),
    .refresh_n(refresh_n), .addr_in(addr_in), .bank_select(bank_select),
    .wr_data_clk_lo(wr_data_clk_lo), .wr_data_clk_hi(wr_data_clk_hi),
    .write_mask(write_mask), .data_bus_in(data_bus_in),
    .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // held well past the two link edges the sync stage needs
  task automatic reset_dut(input logic [1:0] w);
    @(posedge mclk);
    rst_n <= 1'b0;
    width_sel <= w;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge cmd_clk);
  endtask

  // entered just after the rise where the first beat starts
  task automatic beats(input logic [35:0] ln, e0, e1);
    #12;
    chk({read_valid, data_bus_oe}, {1'b1, ln});
    chk(data_bus_out & ln, e0 & ln);
    chk({rd_data_clk_lo, rd_data_clk_hi, rd_data_clk_lo_n,
         rd_data_clk_hi_n}, 4'hC);
    @(negedge cmd_clk);
    #12;
    chk(data_bus_out & ln, e1 & ln);
    chk({read_valid, data_bus_oe}, {1'b1, ln});
    chk({rd_data_clk_lo, rd_data_clk_hi, rd_data_clk_lo_n,
         rd_data_clk_hi_n}, 4'h3);
  endtask

  task automatic quiet();
    @(posedge cmd_clk);
    #12;
    chk({read_valid, data_bus_oe}, 37'h0_0000_0000);
  endtask

  task automatic rd1(input logic [20:0] a, input logic [2:0] b,
                     input logic [35:0] ln, e0, e1);
    u_ctrl.cmd(1'b0, ldpi_pkg::LDPI_CMD_READ, a, b);
    u_ctrl.idle();
    repeat (2) @(posedge cmd_clk);
    beats(ln, e0, e1);
    quiet();
  endtask

  task automatic wait_pulse(input logic sel);
    int n;
    n = 0;
    while ((sel ? refresh_req : mode_update) !== 1'b1 && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if ((sel ? refresh_req : mode_update) !== 1'b1) begin
      err_total++;
      $display("pulse wait timed out at %0t", $time);
      summarize();
    end
  endtask

  task automatic t_width(input logic [1:0] w, input logic [35:0] ln);
    reset_dut(w);
    quiet();
    u_ctrl.wr(21'h00_0005, 3'h1, 36'hA_5A5A_5A5A, 36'h3_C3C3_C3C3,
              1'b0, 1'b0);
    rd1(21'h00_0005, 3'h1, ln, 36'hA_5A5A_5A5A,
        36'h3_C3C3_C3C3);
    $display("width test %0d done", w);
  endtask

  task automatic t_mask();
    u_ctrl.wr(21'h00_0007, 3'h4, 36'h1_1111_1111, 36'h2_2222_2222,
              1'b0, 1'b0);
    u_ctrl.wr(21'h00_0007, 3'h4, 36'h3_3333_3333, 36'h4_4444_4444,
              1'b1, 1'b0);
    rd1(21'h00_0007, 3'h4, ldpi_pkg::LANES_X36, 36'h1_1111_1111,
        36'h4_4444_4444);
    u_ctrl.wr(21'h00_0007, 3'h4, 36'h5_5555_5555, 36'h6_6666_6666,
              1'b0, 1'b1);
    rd1(21'h00_0007, 3'h4, ldpi_pkg::LANES_X36, 36'h5_5555_5555,
        36'h4_4444_4444);
    $display("mask test done");
  endtask

  task automatic t_banks();
    u_ctrl.wr(21'h00_0003, 3'h5, 36'h7_0000_0001, 36'h7_0000_0002,
              1'b0, 1'b0);
    u_ctrl.wr(21'h00_0003, 3'h2, 36'h8_0000_0003, 36'h8_0000_0004,
              1'b0, 1'b0);
    u_ctrl.wr(21'h00_000C, 3'h5, 36'h9_0000_0005, 36'h9_0000_0006,
              1'b0, 1'b0);
    u_ctrl.cmd(1'b0, ldpi_pkg::LDPI_CMD_READ, 21'h00_0003, 3'h5);
    u_ctrl.cmd(1'b0, ldpi_pkg::LDPI_CMD_READ, 21'h00_0003, 3'h2);
    u_ctrl.idle();
    @(posedge cmd_clk);
    beats(ldpi_pkg::LANES_X36, 36'h7_0000_0001, 36'h7_0000_0002);
    @(posedge cmd_clk);
    beats(ldpi_pkg::LANES_X36, 36'h8_0000_0003, 36'h8_0000_0004);
    quiet();
    rd1(21'h00_000C, 3'h5, ldpi_pkg::LANES_X36, 36'h9_0000_0005,
        36'h9_0000_0006);
    $display("bank test done");
  endtask

  task automatic t_mode(input logic [20:0] v);
    u_ctrl.cmd(1'b0, ldpi_pkg::LDPI_CMD_MODE_LOAD, v, 3'h0);
    u_ctrl.idle();
    wait_pulse(1'b0);
    chk(mode_settings, v);
    $display("mode test done");
  endtask

  task automatic t_select();
    logic seen;
    seen = 1'b0;
    u_ctrl.cmd(1'b1, ldpi_pkg::LDPI_CMD_REFRESH, 21'h00_0000, 3'h6);
    u_ctrl.idle();
    repeat (40) begin
      @(posedge mclk);
      #1;
      seen = seen | refresh_req;
    end
    chk(seen, 1'b0);
    u_ctrl.cmd(1'b0, ldpi_pkg::LDPI_CMD_REFRESH, 21'h00_0000, 3'h6);
    u_ctrl.idle();
    wait_pulse(1'b1);
    chk(refresh_bank, 3'h6);
    // deselect right behind a read: the read must still finish alone
    u_ctrl.cmd(1'b0, ldpi_pkg::LDPI_CMD_READ, 21'h00_0005, 3'h1);
    u_ctrl.cmd(1'b1, ldpi_pkg::LDPI_CMD_READ, 21'h00_0003, 3'h5);
    u_ctrl.idle();
    @(posedge cmd_clk);
    beats(ldpi_pkg::LANES_X36, 36'hA_5A5A_5A5A, 36'h3_C3C3_C3C3);
    quiet();
    $display("select test done");
  endtask

  initial begin
    rst_n = 1'b0;
    width_sel = 2'h2;
    err_total = 0;
    checked = 0;
    t_width(ldpi_pkg::LDPI_X9, ldpi_pkg::LANES_X9);
    t_width(ldpi_pkg::LDPI_X18, ldpi_pkg::LANES_X18);
    t_width(ldpi_pkg::LDPI_X36, ldpi_pkg::LANES_X36);
    // spare strap code falls back to the full width
    t_width(2'h3, ldpi_pkg::LANES_X36);
    t_mask();
    t_banks();
    t_mode(21'h1A_5C3E);
    t_mode(21'h05_A3C1);
    t_select();
    summarize();
  end
endmodule
